// ===== eifl_core_model.sv
// core model: vectors to the int2/int6 handler some cycles after a core flag is seen
// assumes flags come from eifl_top on the same clock; i_wait sets the delay
`timescale 1ns/1ps
module eifl_core_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // handler control
  input wire logic i_en,
  input wire logic [1:0] i_wait,
  // pending flags and vector pulses
  input wire logic i_flag2,
  input wire logic i_flag6,
  output logic o_vec2,
  output logic o_vec6
);
  logic [1:0] c2_r;
  logic [1:0] c6_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      c2_r <= 2'h0;
      c6_r <= 2'h0;
      o_vec2 <= 1'b0;
      o_vec6 <= 1'b0;
    end else begin
      o_vec2 <= i_en && i_flag2 && c2_r == i_wait;
      o_vec6 <= i_en && i_flag6 && c6_r == i_wait;
      c2_r <= (i_en && i_flag2 && !o_vec2) ? c2_r + 2'h1 : 2'h0;
      c6_r <= (i_en && i_flag6 && !o_vec6) ? c6_r + 2'h1 : 2'h0;
    end
  end
endmodule // eifl_core_model

// ===== eifl_pkg.sv
// types shared by the external interrupt flag logic
// assumes eifl_regs.svh supplies the numeric constants
package eifl_pkg;
  // one event input per source flag
  typedef enum {
    EIFL_SRC_XFER,
    EIFL_SRC_RTC_SEC,
    EIFL_SRC_RTC_MIN,
    EIFL_SRC_TEMP,
    EIFL_SRC_RTC_ALARM,
    EIFL_SRC_SERIAL,
    EIFL_SRC_EEPROM,
    EIFL_SRC_PULSE_X,
    EIFL_SRC_PULSE_Y,
    EIFL_SRC_PULSE_W,
    EIFL_SRC_PULSE_V,
    EIFL_SRC_COUNT
  } eifl_src_type;
endpackage

// ===== eifl_regs.svh
// register offsets, bit positions and reset values of the external interrupt flag logic
// assumes an 8-bit special-function register space and a 16-bit external register space
`ifndef EIFL_REGS_SVH
`define EIFL_REGS_SVH
`define EIFL_CORE_FLAGS_ADDR 8'hC0
`define EIFL_SRC_A_ADDR 8'hE8
`define EIFL_SRC_B_ADDR 8'hF8
`define EIFL_FLASH_STAT_ADDR 16'h2702
`define EIFL_IRQ_LEVELS_ADDR 16'h2707
`define EIFL_CORE_IRQ2_BIT 1
`define EIFL_CORE_IRQ6_BIT 5
`define EIFL_FLASH_WR_BIT 1
`define EIFL_XFER_BIT 0
`define EIFL_RTC_SEC_BIT 1
`define EIFL_RTC_MIN_BIT 2
`define EIFL_TEMP_BIT 3
`define EIFL_RTC_ALARM_BIT 4
`define EIFL_PULSE_Y_BIT 5
`define EIFL_PULSE_X_BIT 6
`define EIFL_EEPROM_BIT 7
`define EIFL_SERIAL_BIT 7
`define EIFL_PULSE_W_BIT 4
`define EIFL_PULSE_V_BIT 3
`define EIFL_SRC_A_USED 8'hFF
`define EIFL_SRC_B_USED 8'h98
`define EIFL_CORE_FLAGS_RST 8'h00
`define EIFL_SRC_RST 8'h00
`define EIFL_INT2_INPUT 2
`define EIFL_INT6_INPUT 6
`endif

// ===== eifl_top.sv
// external interrupt source flags, core flags for int2/int6, live interrupt levels, flash write status
// assumes the core's special-function port and external register read port are synchronous to i_sys_clk
`timescale 1ns/1ps
`include "eifl_regs.svh"

module eifl_top #(
  parameter int SRC_N = 11,
  parameter int INT_N = 7
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // source events, one-cycle pulses
  input wire logic [SRC_N-1:0] i_src_evt,
  // live interrupt inputs 0 to 6 and core vector acknowledges
  input wire logic [INT_N-1:0] i_int_lvl,
  input wire logic i_vec_irq2,
  input wire logic i_vec_irq6,
  // flash write permission from the security logic
  input wire logic i_flash_write_permitted,
  // special-function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  // external register read port
  input wire logic [15:0] i_x_addr,
  input wire logic i_x_rd,
  output logic [7:0] o_x_rdata,
  // core-level pending flags
  output logic o_core_irq2_flag,
  output logic o_core_irq6_flag
);

  logic [7:0] src_a_r, src_a_nxt;
  logic [7:0] src_b_r, src_b_nxt;
  logic [7:0] core_r, core_nxt;
  logic [7:0] sfr_rdata_r, sfr_rdata_nxt;
  logic [7:0] x_rdata_r, x_rdata_nxt;
  logic int2_d_r, int6_d_r;
  logic [7:0] set_a, set_b;
  logic irq2_set, irq6_set;

  // place an event bit into an 8-bit flag image
  function automatic logic [7:0] eifl_bit(input logic en, input int pos);
    logic [7:0] v;
    v = 8'h00;
    v[pos[2:0]] = en;
    return v;
  endfunction

  // set wins over a written zero; unused bits stay zero
  function automatic logic [7:0] eifl_flag_next(input logic [7:0] cur, input logic [7:0] set,
                                                input logic wr, input logic [7:0] wd,
                                                input logic [7:0] used);
    return (set | (wr ? wd : cur)) & used;
  endfunction

  // event to bit mapping of the two source flag registers
  always_comb begin
    set_a = eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_XFER], `EIFL_XFER_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_RTC_SEC], `EIFL_RTC_SEC_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_RTC_MIN], `EIFL_RTC_MIN_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_TEMP], `EIFL_TEMP_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_RTC_ALARM], `EIFL_RTC_ALARM_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_PULSE_Y], `EIFL_PULSE_Y_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_PULSE_X], `EIFL_PULSE_X_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_EEPROM], `EIFL_EEPROM_BIT);
    set_b = eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_SERIAL], `EIFL_SERIAL_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_PULSE_W], `EIFL_PULSE_W_BIT)
          | eifl_bit(i_src_evt[eifl_pkg::EIFL_SRC_PULSE_V], `EIFL_PULSE_V_BIT);
  end

  // core flags follow rising edges of the int2 and int6 inputs
  assign irq2_set = i_int_lvl[`EIFL_INT2_INPUT] & ~int2_d_r;
  assign irq6_set = i_int_lvl[`EIFL_INT6_INPUT] & ~int6_d_r;

  // flag state next values
  always_comb begin
    logic wr_a, wr_b, wr_c;
    wr_a = i_sfr_wr && (i_sfr_addr == `EIFL_SRC_A_ADDR);
    wr_b = i_sfr_wr && (i_sfr_addr == `EIFL_SRC_B_ADDR);
    wr_c = i_sfr_wr && (i_sfr_addr == `EIFL_CORE_FLAGS_ADDR);
    src_a_nxt = eifl_flag_next(src_a_r, set_a, wr_a, i_sfr_wdata, `EIFL_SRC_A_USED);
    src_b_nxt = eifl_flag_next(src_b_r, set_b, wr_b, i_sfr_wdata, `EIFL_SRC_B_USED);
    core_nxt = wr_c ? i_sfr_wdata : core_r;
    // a vector clear takes the flag down unless a new edge arrives in the same cycle
    if (i_vec_irq2) begin
      core_nxt[`EIFL_CORE_IRQ2_BIT] = 1'b0;
    end
    if (i_vec_irq6) begin
      core_nxt[`EIFL_CORE_IRQ6_BIT] = 1'b0;
    end
    if (irq2_set) begin
      core_nxt[`EIFL_CORE_IRQ2_BIT] = 1'b1;
    end
    if (irq6_set) begin
      core_nxt[`EIFL_CORE_IRQ6_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      src_a_r <= `EIFL_SRC_RST;
      src_b_r <= `EIFL_SRC_RST;
      core_r <= `EIFL_CORE_FLAGS_RST;
      int2_d_r <= 1'b0;
      int6_d_r <= 1'b0;
    end else begin
      src_a_r <= src_a_nxt;
      src_b_r <= src_b_nxt;
      core_r <= core_nxt;
      int2_d_r <= i_int_lvl[`EIFL_INT2_INPUT];
      int6_d_r <= i_int_lvl[`EIFL_INT6_INPUT];
    end
  end

  // read data next values; unmapped addresses and idle cycles read zero
  always_comb begin
    sfr_rdata_nxt = 8'h00;
    if (!i_sfr_rd) begin
      sfr_rdata_nxt = 8'h00;
    end else if (i_sfr_addr == `EIFL_SRC_A_ADDR) begin
      sfr_rdata_nxt = src_a_r;
    end else if (i_sfr_addr == `EIFL_SRC_B_ADDR) begin
      sfr_rdata_nxt = src_b_r;
    end else if (i_sfr_addr == `EIFL_CORE_FLAGS_ADDR) begin
      sfr_rdata_nxt = core_r;
    end
    x_rdata_nxt = 8'h00;
    if (!i_x_rd) begin
      x_rdata_nxt = 8'h00;
    end else if (i_x_addr == `EIFL_FLASH_STAT_ADDR) begin
      x_rdata_nxt = eifl_bit(i_flash_write_permitted, `EIFL_FLASH_WR_BIT);
    end else if (i_x_addr == `EIFL_IRQ_LEVELS_ADDR) begin
      // sampled straight from the pins at the read; nothing holds a short pulse
      x_rdata_nxt = {1'b0, i_int_lvl};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sfr_rdata_r <= 8'h00;
      x_rdata_r <= 8'h00;
    end else begin
      sfr_rdata_r <= sfr_rdata_nxt;
      x_rdata_r <= x_rdata_nxt;
    end
  end

  assign o_sfr_rdata = sfr_rdata_r;
  assign o_x_rdata = x_rdata_r;
  assign o_core_irq2_flag = core_r[`EIFL_CORE_IRQ2_BIT];
  assign o_core_irq6_flag = core_r[`EIFL_CORE_IRQ6_BIT];

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_flash_status;
    i_x_rd && i_x_addr == `EIFL_FLASH_STAT_ADDR |=> o_x_rdata == {6'h00, $past(i_flash_write_permitted), 1'b0};
  endproperty
  a_flash_status: assert property (p_flash_status) else $error("flash status read wrong");

  property p_reset_zero;
    $past(i_rst) |-> src_a_r == 8'h00 && src_b_r == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("source flags not zero after reset");

  property p_serial_flag;
    i_src_evt[eifl_pkg::EIFL_SRC_SERIAL] ##1 (i_sfr_rd && i_sfr_addr == `EIFL_SRC_B_ADDR) |=> o_sfr_rdata[7];
  endproperty
  a_serial_flag: assert property (p_serial_flag) else $error("serial flag not seen by read");

  property p_flag_sticky;
    src_a_r[0] && !(i_sfr_wr && i_sfr_addr == `EIFL_SRC_A_ADDR) |=> src_a_r[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("source flag dropped without a write");

  property p_flag_sticky_b;
    src_b_r[7] && !(i_sfr_wr && i_sfr_addr == `EIFL_SRC_B_ADDR) |=> src_b_r[7];
  endproperty
  a_flag_sticky_b: assert property (p_flag_sticky_b) else $error("serial flag dropped without a write");

  property p_vector_clear;
    i_vec_irq2 && !irq2_set && !(i_sfr_wr && i_sfr_addr == `EIFL_CORE_FLAGS_ADDR) |=> !o_core_irq2_flag;
  endproperty
  a_vector_clear: assert property (p_vector_clear) else $error("core int2 flag not cleared on vector");

  property p_vector_clear6;
    i_vec_irq6 && !irq6_set && !(i_sfr_wr && i_sfr_addr == `EIFL_CORE_FLAGS_ADDR) |=> !o_core_irq6_flag;
  endproperty
  a_vector_clear6: assert property (p_vector_clear6) else $error("core int6 flag not cleared on vector");

  property p_edge_sets_irq2;
    i_int_lvl[`EIFL_INT2_INPUT] && !$past(i_int_lvl[`EIFL_INT2_INPUT]) |=> o_core_irq2_flag;
  endproperty
  a_edge_sets_irq2: assert property (p_edge_sets_irq2) else $error("core int2 flag not set by input edge");

  property p_levels_live;
    i_x_rd && i_x_addr == `EIFL_IRQ_LEVELS_ADDR |=> o_x_rdata == {1'b0, $past(i_int_lvl)};
  endproperty
  a_levels_live: assert property (p_levels_live) else $error("live level read wrong");

  property p_levels_unlatched;
    (i_x_rd && i_x_addr == `EIFL_IRQ_LEVELS_ADDR && !i_int_lvl[0]) ##1 i_int_lvl[0] |-> !o_x_rdata[0];
  endproperty
  a_levels_unlatched: assert property (p_levels_unlatched) else $error("level read not from read cycle");

  property p_set_wins;
    i_src_evt[eifl_pkg::EIFL_SRC_XFER] && i_sfr_wr && i_sfr_addr == `EIFL_SRC_A_ADDR |=> src_a_r[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

endmodule // eifl_top

// ===== tb.sv
// testbench of eifl_top with the core model on the vector side
// assumes inputs change at the falling edge and read data stands one cycle
`timescale 1ns/1ps
`include "eifl_regs.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [10:0] evt = '0;
  logic [6:0] lvl = '0;
  logic permit = 1'b0;
  logic [7:0] sa = 8'h00;
  logic [7:0] wd = 8'h00;
  logic swr = 1'b0;
  logic srd = 1'b0;
  logic [15:0] xa = 16'h0000;
  logic xrd = 1'b0;
  logic en = 1'b0;
  logic [1:0] dly = 2'h0;
  logic [7:0] srdata, xrdata;
  logic f2, f6, v2, v6;
  int n_fail = 0;
  int total_checks = 0;
  // event index, register, expected flag mask
  logic [23:0] rows [11] = '{24'h00E801, 24'h01E802, 24'h02E804, 24'h03E808, 24'h04E810, 24'h05F880,
                             24'h06E880, 24'h07E840, 24'h08E820, 24'h09F810, 24'h0AF808};
  always #10 clk = ~clk;
  eifl_top i_eifl_top (.i_sys_clk(clk), .i_rst(rst), .i_src_evt(evt), .i_int_lvl(lvl), .i_vec_irq2(v2),
    .i_vec_irq6(v6), .i_flash_write_permitted(permit), .i_sfr_addr(sa), .i_sfr_wr(swr), .i_sfr_wdata(wd),
    .i_sfr_rd(srd), .o_sfr_rdata(srdata), .i_x_addr(xa), .i_x_rd(xrd), .o_x_rdata(xrdata),
    .o_core_irq2_flag(f2), .o_core_irq6_flag(f6));
  eifl_core_model i_eifl_core_model (.i_sys_clk(clk), .i_rst(rst), .i_en(en), .i_wait(dly), .i_flag2(f2),
    .i_flag6(f6), .o_vec2(v2), .o_vec6(v6));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); sa = a; wd = d; swr = 1'b1;
    @(negedge clk); swr = 1'b0;
  endtask
  // read data is registered at the taking edge, so it is seen at the next falling edge
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk); sa = a; srd = 1'b1;
    @(negedge clk); srd = 1'b0; chk(what, srdata, exp);
  endtask
  task automatic x_rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(negedge clk); xa = a; xrd = 1'b1;
    @(negedge clk); xrd = 1'b0; chk(what, xrdata, exp);
  endtask
  task automatic wait_flag(input logic sel, input logic val);
    int i;
    for (i = 0; i < 8 && (sel ? f6 : f2) !== val; i++) @(negedge clk);
    if (i == 8) begin
      n_fail++;
      stop_test();
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    sfr_rd(`EIFL_CORE_FLAGS_ADDR, 8'h00, "core flags reset");
    sfr_rd(`EIFL_SRC_A_ADDR, 8'h00, "source a reset");
    sfr_rd(`EIFL_SRC_B_ADDR, 8'h00, "source b reset");
    foreach (rows[k]) begin
      // event still high while the read is taken, so the read directly follows the setting edge
      @(negedge clk); evt[rows[k][23:16]] = 1'b1;
      sfr_rd(rows[k][15:8], rows[k][7:0], "flag set");
      evt = '0;
      repeat (3) @(negedge clk);
      sfr_rd(rows[k][15:8], rows[k][7:0], "flag held");
      sfr_wr(rows[k][15:8], 8'h00);
      sfr_rd(rows[k][15:8], 8'h00, "flag cleared");
    end
    @(negedge clk); evt[0] = 1'b1; sa = `EIFL_SRC_A_ADDR; wd = 8'h00; swr = 1'b1;
    @(negedge clk); evt = '0; swr = 1'b0;
    sfr_rd(`EIFL_SRC_A_ADDR, 8'h01, "set beats clear");
    sfr_wr(`EIFL_SRC_A_ADDR, 8'h00);
    sfr_wr(`EIFL_SRC_B_ADDR, 8'hFF);
    sfr_rd(`EIFL_SRC_B_ADDR, 8'h98, "source b unused bits");
    sfr_wr(`EIFL_SRC_B_ADDR, 8'h00);
    sfr_rd(8'h90, 8'h00, "unmapped read");
    permit = 1'b1;
    x_rd(`EIFL_FLASH_STAT_ADDR, 8'h02, "flash permit on");
    permit = 1'b0;
    x_rd(`EIFL_FLASH_STAT_ADDR, 8'h00, "flash permit off");
    // slow vector on int2, prompt vector on int6
    en = 1'b1; dly = 2'h2; lvl[2] = 1'b1;
    wait_flag(1'b0, 1'b1);
    repeat (2) @(negedge clk);
    chk("irq2 held until vector", {7'h00, f2}, 8'h01);
    wait_flag(1'b0, 1'b0);
    @(negedge clk);
    chk("irq2 cleared by vector", {7'h00, f2}, 8'h00);
    dly = 2'h0; lvl[6] = 1'b1;
    wait_flag(1'b1, 1'b1);
    wait_flag(1'b1, 1'b0);
    chk("irq6 cleared by vector", {7'h00, f6}, 8'h00);
    en = 1'b0; lvl = '0;
    repeat (2) @(negedge clk);
    lvl[2] = 1'b1; lvl[6] = 1'b1;
    wait_flag(1'b0, 1'b1);
    wait_flag(1'b1, 1'b1);
    sfr_wr(`EIFL_CORE_FLAGS_ADDR, 8'hFD);
    chk("irq2 after masked clear", {7'h00, f2}, 8'h00);
    chk("irq6 kept by masked clear", {7'h00, f6}, 8'h01);
    sfr_rd(`EIFL_CORE_FLAGS_ADDR, 8'hFD, "core flags after masked clear");
    x_rd(`EIFL_IRQ_LEVELS_ADDR, 8'h44, "live levels");
    lvl = 7'h2B;
    x_rd(`EIFL_IRQ_LEVELS_ADDR, 8'h2B, "live levels follow");
    // mid-run reset must clear flags that are already set
    @(negedge clk); evt = 11'h7FF;
    @(negedge clk); evt = '0;
    sfr_rd(`EIFL_SRC_A_ADDR, 8'hFF, "all events a");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    sfr_rd(`EIFL_SRC_A_ADDR, 8'h00, "source a after reset");
    sfr_rd(`EIFL_SRC_B_ADDR, 8'h00, "source b after reset");
    sfr_rd(`EIFL_CORE_FLAGS_ADDR, 8'h00, "core flags after reset");
    stop_test();
  end
endmodule // tb
